/* File: rtl/sensor_serial_access_port.sv */
/*
 * serial access port of the angle sensor die: mode 3 spi slave onto the
 * serial registers, and supply line manchester receiver with open drain
 * read response on the pwm pin.
 * assumes spi and supply pins are asynchronous and sampled here, and that
 * i_pwm_angle is the angle pwm stream from logic on i_clock.
 */
`default_nettype none

// Summary of operation
// (R1) spi frames are 16, 17 or 20 bits; 20 adds four crc bits
// (R2) 17 bit frames accepted only while seventeen bit enable is set
// (R3) extra clock warning on overlong frames, never on clean allowed lengths
// (R4) shared bus host sends 21 bits: 20 bit frame shifted, trailing zero
// (R5) a 21 bit frame repeats the top crc bit on the last edge
// (R6) write frame: zero, write bit, six address bits, eight data, crc
// (R7) host writes a full register as separate even and odd byte writes
// (R8) mosi sampled on each rising sclk edge
// (R9) read data returns in the next frame, reads pipeline back to back
// (R10) all zero frame reads address zero, no effect, reads as zero
// (R11) host ignores miso unless previous frame held a read
// (R12) even read gives full word, odd read gives byte, upper zero
// (R13) more than 16 clocks out appends crc on miso automatically
// (R14) mosi crc ignored unless crc check enable set
// (R15) checked frame with bad crc is dropped and crc warning set
// (R16) crc x^4+x+1, preset ones, bit 15 first, sent c3 to c0
// (R17) host waits for extended read done before reading read data
// (R18) manchester: rising mid edge is 0, falling is 1, msb first
// (R19) die identity taken from the two die select pins, four dies
// (R20) manchester disable set ignores all supply line traffic
// (R21) measure host bit rate and answer reads at that rate
// (R22) no action on supply line commands before a valid access code
// (R23) entering manchester mode stops angle pwm at once
// (R24) spi mode 3: clock idles high, capture on rising edge
// (R25) access code is broadcast write, address all ones, data 62d2; code does not check the target field
// (R26) each host manchester command starts with two zero sync bits
// (R27) chip select release clears the frame and judges its length
module sensor_serial_access_port
    import ssap_pkg::*;
#(
    parameter int CNT_W = 20
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_reset_n,
    // spi pins
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_mosi,
    output logic o_miso,
    // configuration
    input wire logic i_seventeen_bit_frame_enable,
    input wire logic i_mosi_crc_check_enable,
    input wire logic i_manchester_disable,
    input wire logic i_clear_warnings,
    // die select and supply line
    input wire logic i_die_select_pin_low,
    input wire logic i_die_select_pin_high,
    input wire logic i_supply_level,
    // pwm pin, open drain
    input wire logic i_pwm_angle,
    output logic o_pwm_out,
    output logic o_pwm_oe,
    // status
    output logic o_extra_clock_warning,
    output logic o_crc_error_warning,
    output logic o_manchester_mode
);

    typedef struct packed {
        logic [PIN_COUNT-1:0] s0;
        logic [PIN_COUNT-1:0] s1;
        logic [PIN_COUNT-1:0] s2;
        logic [PIN_COUNT-1:0] flt;
        logic [5:0] bit_cnt;
        logic [20:0] rx;
        logic [20:0] tx;
        logic miso;
        logic [15:0] tx_word;
        logic [5:0] spi_rd_addr;
        logic spi_rd_wait;
        logic extra_warn;
        logic crc_warn;
        man_state_t mstate;
        logic [CNT_W-1:0] period;
        logic [CNT_W-1:0] cnt;
        logic [29:0] mbits;
        logic [5:0] mcount;
        logic mode;
        logic m_req_wr;
        logic m_req_rd;
        logic [5:0] m_addr;
        logic [15:0] m_data;
        logic m_rd_wait;
        logic tx_active;
        logic [31:0] pat;
        logic [CNT_W-1:0] half_cnt;
        logic [5:0] slots;
        logic pwm_oe;
    } state_t;

    state_t s;
    state_t next_s;
    mem_req_t mem_req;
    logic [15:0] mem_rdata;
    logic [PIN_COUNT-1:0] agree;
    logic [PIN_COUNT-1:0] rise;
    logic [PIN_COUNT-1:0] fall;
    logic spi_end;
    logic frame_ok;
    logic has_crc;
    logic crc_bad;
    logic spi_wr;
    logic spi_rd;
    logic man_grant;
    logic [15:0] payload;
    logic [3:0] rx_crc;
    logic [CNT_W:0] win_lo;
    logic [CNT_W:0] win_hi;
    logic [1:0] die_id;
    logic [3:0] target;
    logic id_match;

    // ========================================================================
    // register memory
    // ========================================================================
    ssap_reg_mem #(
        .WORDS(32)
    ) u_mem (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_req(mem_req),
        .o_rd_data(mem_rdata)
    );

    // ========================================================================
    // next state
    // ========================================================================
    always_comb begin
        next_s = s;
        // three stage pin sampling, a change counts once stages two and
        // three agree
        next_s.s0 = {i_die_select_pin_high, i_die_select_pin_low,
                     i_supply_level, i_mosi, i_cs_n, i_sclk};
        next_s.s1 = s.s0;
        next_s.s2 = s.s1;
        agree = ~(s.s1 ^ s.s2);
        rise = agree & s.s2 & ~s.flt;
        fall = agree & ~s.s2 & s.flt;
        next_s.flt = (agree & s.s2) | (~agree & s.flt);

        // frame fields by length
        spi_end = rise[PIN_CS_N];
        frame_ok = 1'b0;
        has_crc = 1'b0;
        payload = s.rx[15:0];
        rx_crc = s.rx[3:0];
        case (s.bit_cnt)
            FRAME_LEN_16: begin
                frame_ok = 1'b1; // R1
            end
            FRAME_LEN_17: begin
                frame_ok = i_seventeen_bit_frame_enable; // R2
                payload = s.rx[16:1];
            end
            FRAME_LEN_20: begin
                frame_ok = 1'b1; // R1
                has_crc = 1'b1;
                payload = s.rx[19:4];
            end
            FRAME_LEN_21: begin
                frame_ok = 1'b1;
                has_crc = 1'b1;
                payload = s.rx[20:5];
                rx_crc = s.rx[4:1];
            end
            default: begin
                frame_ok = 1'b0;
            end
        endcase
        crc_bad = has_crc && i_mosi_crc_check_enable
                  && (crc4_calc(payload) != rx_crc); // R14
        // frame start bit zero, then write bit, address and data
        spi_wr = spi_end && frame_ok && !crc_bad && !payload[15]
                 && payload[14] && (payload[13:9] != 5'h00); // R6 R10
        spi_rd = spi_end && frame_ok && !crc_bad && !payload[15]
                 && !payload[14];

        // spi shifting while selected, cleared on select
        if (fall[PIN_CS_N]) begin
            next_s.bit_cnt = '0; // R27
            next_s.rx = '0;
            next_s.tx = {s.tx_word, crc4_calc(s.tx_word),
                         1'b0}; // R13 R16
            next_s.tx[0] = next_s.tx[4]; // R5
        end else if (!s.flt[PIN_CS_N]) begin
            if (rise[PIN_SCLK]) begin
                next_s.rx = {s.rx[19:0], s.flt[PIN_MOSI]}; // R8 R24
                if (s.bit_cnt != BIT_CNT_MAX) begin
                    next_s.bit_cnt = s.bit_cnt + 6'h01;
                end
            end
            if (fall[PIN_SCLK]) begin
                next_s.miso = s.tx[20]; // R24
                next_s.tx = {s.tx[19:0], 1'b0};
            end
        end
        if (spi_end) begin
            next_s.bit_cnt = '0; // R27
            next_s.miso = 1'b0;
            next_s.tx_word = 16'h0000;
            next_s.spi_rd_addr = payload[13:8];
        end
        next_s.spi_rd_wait = spi_rd; // R9
        if (s.spi_rd_wait) begin
            next_s.tx_word = read_format(s.spi_rd_addr, mem_rdata); // R12
        end

        // sticky warnings, a set wins over a clear
        next_s.extra_warn = (s.extra_warn & ~i_clear_warnings)
                            | (spi_end && !frame_ok
                               && s.bit_cnt > FRAME_LEN_16); // R3
        next_s.crc_warn = (s.crc_warn & ~i_clear_warnings)
                          | (spi_end && frame_ok && crc_bad); // R15

        // manchester receive, window from the measured bit period
        win_lo = {2'b00, s.period[CNT_W-1:1]} + {3'b000, s.period[CNT_W-1:2]};
        win_hi = {1'b0, s.period} + {3'b000, s.period[CNT_W-1:2]};
        die_id = {s.flt[PIN_DIE_HIGH], s.flt[PIN_DIE_LOW]}; // R19
        target = (s.mcount == MAN_WRITE_BITS) ? s.mbits[28:25]
                                              : s.mbits[12:9];
        id_match = (target == 4'h0) || target[die_id];
        if (s.cnt != '1) begin
            next_s.cnt = s.cnt + 1'b1;
        end
        case (s.mstate)
            MAN_IDLE: begin
                if (rise[PIN_SUPPLY]) begin
                    next_s.cnt = '0;
                    next_s.mstate = MAN_SYNC; // R26
                end
            end
            MAN_SYNC: begin
                if (rise[PIN_SUPPLY]) begin
                    next_s.period = s.cnt + 1'b1; // R21
                    next_s.cnt = '0;
                    next_s.mcount = '0;
                    next_s.mbits = '0;
                    next_s.mstate = MAN_DATA;
                end else if (s.cnt == '1) begin
                    next_s.mstate = MAN_IDLE;
                end
            end
            MAN_DATA: begin
                if ((rise[PIN_SUPPLY] || fall[PIN_SUPPLY])
                    && {1'b0, s.cnt} >= win_lo) begin
                    next_s.mbits = {s.mbits[28:0], fall[PIN_SUPPLY]}; // R18
                    if (s.mcount != BIT_CNT_MAX) begin
                        next_s.mcount = s.mcount + 6'h01;
                    end
                    next_s.cnt = '0;
                end else if ({1'b0, s.cnt} > win_hi) begin
                    next_s.mstate = MAN_IDLE;
                    if (s.mcount == MAN_WRITE_BITS && !s.mbits[29]
                        && s.mbits[24:19] == ACCESS_ADDR
                        && s.mbits[18:3] == ACCESS_DATA) begin
                        next_s.mode = 1'b1; // R25
                    end else if (s.mode && id_match) begin // R22
                        if (s.mcount == MAN_WRITE_BITS && !s.mbits[29]) begin
                            next_s.m_req_wr = 1'b1;
                            next_s.m_addr = s.mbits[24:19];
                            next_s.m_data = s.mbits[18:3];
                        end else if (s.mcount == MAN_READ_BITS
                                     && s.mbits[13]) begin
                            next_s.m_req_rd = 1'b1;
                            next_s.m_addr = s.mbits[8:3];
                        end
                    end
                end
            end
            default: begin
                next_s.mstate = MAN_IDLE;
            end
        endcase
        if (i_manchester_disable) begin
            next_s.mstate = MAN_IDLE; // R20
        end

        // memory access, spi first, supply line waits its turn
        mem_req = '0;
        man_grant = 1'b0;
        if (spi_wr || spi_rd) begin
            mem_req.wr_en = spi_wr;
            mem_req.rd_en = spi_rd;
            mem_req.addr = payload[13:9];
            mem_req.be = payload[8] ? 2'b01 : 2'b10;
            mem_req.wdata = {payload[7:0], payload[7:0]};
        end else if ((s.m_req_wr && s.m_addr[5:1] != 5'h00) || s.m_req_rd) begin
            man_grant = 1'b1;
            mem_req.wr_en = s.m_req_wr;
            mem_req.rd_en = s.m_req_rd;
            mem_req.addr = s.m_addr[5:1];
            mem_req.be = 2'b11;
            mem_req.wdata = s.m_data;
        end
        if (man_grant || (s.m_req_wr && s.m_addr[5:1] == 5'h00)) begin
            next_s.m_req_wr = 1'b0;
            next_s.m_req_rd = 1'b0;
        end
        next_s.m_rd_wait = man_grant && s.m_req_rd;

        // response on the pwm pin at the measured rate
        if (s.m_rd_wait) begin
            next_s.pat = man_pattern(read_format(s.m_addr, mem_rdata));
            next_s.tx_active = 1'b1;
            next_s.half_cnt = '0;
            next_s.slots = '0;
        end else if (s.tx_active) begin
            next_s.half_cnt = s.half_cnt + 1'b1;
            if ({1'b0, s.half_cnt} + 1'b1 >= {2'b00, s.period[CNT_W-1:1]}) begin
                next_s.half_cnt = '0; // R21
                next_s.pat = {s.pat[30:0], 1'b1};
                next_s.slots = s.slots + 6'h01;
                if (s.slots == TX_LAST_SLOT) begin
                    next_s.tx_active = 1'b0;
                end
            end
        end
        // a low level pulls the pin, angle pwm stops in manchester mode
        next_s.pwm_oe = next_s.mode ? (next_s.tx_active & ~next_s.pat[31])
                                    : ~i_pwm_angle; // R23
    end

    // ========================================================================
    // state register
    // ========================================================================
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            s <= '0;
            s.s0 <= PIN_IDLE;
            s.s1 <= PIN_IDLE;
            s.s2 <= PIN_IDLE;
            s.flt <= PIN_IDLE;
        end else begin
            s <= next_s;
        end
    end

    // outputs straight from flip-flops, open drain data held low
    assign o_miso = s.miso;
    assign o_pwm_out = s.mbits[0] & 1'b0;
    assign o_pwm_oe = s.pwm_oe;
    assign o_extra_clock_warning = s.extra_warn;
    assign o_crc_error_warning = s.crc_warn;
    assign o_manchester_mode = s.mode;

    // ========================================================================
    // checks
    // ========================================================================
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_reset_n);

    a_overlong_frame: assert property ( // R3
        spi_end && s.bit_cnt == 6'h12 |=> s.extra_warn)
        else $error("overlong frame did not raise extra clock warning");
    a_clean_frame: assert property ( // R3
        spi_end && s.bit_cnt == FRAME_LEN_20 && !s.extra_warn
        && !i_clear_warnings |=> !s.extra_warn)
        else $error("clean 20 bit frame raised extra clock warning");
    a_seventeen_gate: assert property ( // R2
        spi_end && s.bit_cnt == FRAME_LEN_17 && !i_seventeen_bit_frame_enable
        |-> !mem_req.wr_en ##1 s.extra_warn)
        else $error("17 bit frame accepted while disabled");
    a_crc_discard: assert property ( // R15
        spi_end && frame_ok && crc_bad |-> !mem_req.wr_en ##1 s.crc_warn)
        else $error("bad crc frame not discarded");
    a_crc_ignored: assert property ( // R14
        $rose(s.crc_warn) |-> $past(i_mosi_crc_check_enable))
        else $error("crc warning while crc check disabled");
    a_miso_shift: assert property ( // R13
        fall[PIN_SCLK] && !s.flt[PIN_CS_N] && !rise[PIN_CS_N]
        |=> o_miso == $past(s.tx[20]))
        else $error("miso did not follow the shift register");
    a_pwm_stops: assert property ( // R23
        $rose(s.mode) |-> !o_pwm_oe)
        else $error("angle pwm still driven after mode entry");
    a_disable_idle: assert property ( // R20
        i_manchester_disable |=> s.mstate == MAN_IDLE)
        else $error("supply line decoding while disabled");
    a_locked_out: assert property ( // R22
        !s.mode |-> !man_grant)
        else $error("supply line command acted on before access code");
    a_reg0_safe: assert property ( // R10
        mem_req.wr_en |-> mem_req.addr != 5'h00)
        else $error("write reached register zero");

endmodule : sensor_serial_access_port

`default_nettype wire

/* File: rtl/ssap_reg_mem.sv */
/*
 * serial register memory: 32 words of two bytes, byte lane writes,
 * registered read data one cycle after the read request.
 * assumes the caller never reads and writes the same word in one cycle.
 */
`default_nettype none

module ssap_reg_mem
    import ssap_pkg::*;
#(
    parameter int WORDS = 32
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_reset_n,
    // access
    input wire mem_req_t i_req,
    output logic [15:0] o_rd_data
);

    typedef struct packed {
        logic [WORDS-1:0][15:0] words;
        logic [15:0] rd_data;
    } mem_state_t;

    mem_state_t s;
    mem_state_t next_s;

    // ========================================================================
    // byte lane writes and registered read
    // ========================================================================
    always_comb begin
        next_s = s;
        if (i_req.rd_en) begin
            next_s.rd_data = s.words[i_req.addr];
        end
        for (int b = 0; b < 2; b++) begin
            if (i_req.wr_en && i_req.be[b]) begin
                next_s.words[i_req.addr][b*8 +: 8] = i_req.wdata[b*8 +: 8];
            end
        end
    end

    // state register
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign o_rd_data = s.rd_data;

endmodule : ssap_reg_mem

`default_nettype wire

/* File: shared/ssap_pkg.sv */
/*
 * shared constants, types and helpers of the sensor serial access port.
 * assumes a design clock of 200 MHz and a byte addressed serial register space of 16 bit words.
 */
`default_nettype none

package ssap_pkg;

    // ========================================================================
    // spi frame lengths and crc
    // ========================================================================
    localparam logic [5:0] FRAME_LEN_16 = 6'h10;
    localparam logic [5:0] FRAME_LEN_17 = 6'h11;
    localparam logic [5:0] FRAME_LEN_20 = 6'h14;
    localparam logic [5:0] FRAME_LEN_21 = 6'h15;
    localparam logic [5:0] BIT_CNT_MAX = 6'h3F;
    localparam logic [3:0] CRC_PRESET = 4'hF;

    // ========================================================================
    // supply line command layout
    // ========================================================================
    localparam logic [5:0] MAN_WRITE_BITS = 6'h1E;
    localparam logic [5:0] MAN_READ_BITS = 6'h0E;
    localparam logic [5:0] ACCESS_ADDR = 6'h3F;
    localparam logic [15:0] ACCESS_DATA = 16'h62D2;
    localparam logic [5:0] TX_LAST_SLOT = 6'h1F;

    // ========================================================================
    // pin synchroniser slots
    // ========================================================================
    localparam int PIN_SCLK = 0;
    localparam int PIN_CS_N = 1;
    localparam int PIN_MOSI = 2;
    localparam int PIN_SUPPLY = 3;
    localparam int PIN_DIE_LOW = 4;
    localparam int PIN_DIE_HIGH = 5;
    localparam int PIN_COUNT = 6;
    localparam logic [PIN_COUNT-1:0] PIN_IDLE = 6'h03;

    typedef enum logic [1:0] {
        MAN_IDLE,
        MAN_SYNC,
        MAN_DATA
    } man_state_t;

    // one access to the serial register memory
    typedef struct packed {
        logic wr_en;
        logic rd_en;
        logic [4:0] addr;
        logic [1:0] be;
        logic [15:0] wdata;
    } mem_req_t;

    // crc x^4+x+1, preset all ones, bit 15 first
    function automatic logic [3:0] crc4_calc(input logic [15:0] d);
        logic [3:0] c;
        logic inv;
        c = CRC_PRESET;
        for (int i = 15; i >= 0; i--) begin
            inv = d[i] ^ c[3];
            c = {c[2], c[1], c[0] ^ inv, inv};
        end
        return c;
    endfunction : crc4_calc

    // even address gives the word, odd address the low byte only, address zero reads as zero
    function automatic logic [15:0] read_format(input logic [5:0] addr,
                                                input logic [15:0] word);
        logic [15:0] r;
        r = word;
        if (addr == 6'h00) begin
            r = 16'h0000;
        end else if (addr[0]) begin
            r = {8'h00, word[7:0]};
        end
        return r;
    endfunction : read_format

    // manchester line levels, two half slots per bit, msb first
    function automatic logic [31:0] man_pattern(input logic [15:0] d);
        logic [31:0] p;
        p = '0;
        for (int i = 0; i < 16; i++) begin
            p[31-2*i] = d[15-i];
            p[30-2*i] = ~d[15-i];
        end
        return p;
    endfunction : man_pattern

endpackage : ssap_pkg

`default_nettype wire

/* File: test/sensor_serial_access_port_tb_top.sv */
/* bench of the serial access port: writes, pipelined reads, crc, lengths.
   assumes the host model drives the spi pins of the design. */
`default_nettype none

module sensor_serial_access_port_tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    // ========================================================================
    // signals and instances
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic en17 = 1'b0;
    logic crc_en = 1'b0;
    logic clr = 1'b0;
    logic angle = 1'b1;
    logic [3:0] flip = 4'h0;
    logic mdis = 1'b0;
    logic dlo = 1'b1;
    logic sup = 1'b0;
    logic sclk, cs_n, mosi, miso, pwm_out, pwm_oe, xw, cw, mode;
    logic [20:0] r;
    int num_errors = 0;
    int n_checks = 0;

    // clock
    always #2.5 clk = ~clk;

    sensor_serial_access_port #(.CNT_W(12)) u_sensor_serial_access_port (
        .i_clock(clk), .i_reset_n(rst_n), .i_sclk(sclk), .i_cs_n(cs_n),
        .i_mosi(mosi), .o_miso(miso), .i_seventeen_bit_frame_enable(en17),
        .i_mosi_crc_check_enable(crc_en), .i_manchester_disable(mdis),
        .i_clear_warnings(clr), .i_die_select_pin_low(dlo),
        .i_die_select_pin_high(1'b0), .i_supply_level(sup),
        .i_pwm_angle(angle), .o_pwm_out(pwm_out), .o_pwm_oe(pwm_oe),
        .o_extra_clock_warning(xw), .o_crc_error_warning(cw),
        .o_manchester_mode(mode));

    ssap_host_model u_ssap_host_model (
        .i_clock(clk), .o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi),
        .i_miso(miso));

    // ========================================================================
    // helpers
    function automatic logic [3:0] crc(input logic [15:0] d);
        logic [3:0] c;
        logic x;
        c = 4'hF;
        for (int i = 15; i >= 0; i--) begin
            x = d[i] ^ c[3];
            c = {c[2:1], c[0] ^ x, x};
        end
        return c;
    endfunction : crc

    task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %0t word %h expected %h", $time, g, e);
        end
    endtask : chk_word

    task automatic chk_bit(input logic g, input logic e);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %0t flag %b expected %b", $time, g, e);
        end
    endtask : chk_bit

    // send a command, with crc and trailing zero as the length asks
    task automatic xfer(input logic [15:0] c, input int n);
        logic [20:0] d;
        d = {5'h00, c};
        if (n == 17) d = {4'h0, c, 1'b0};
        if (n == 20) d = {1'b0, c, crc(c) ^ flip};
        if (n == 21) d = {c, crc(c), 1'b0};
        u_ssap_host_model.frame(d, n, r);
        repeat (8) @(negedge clk);
    endtask : xfer

    // supply line command: two zero sync bits, then n bits msb first
    task automatic mcmd(input logic [29:0] w, input int n);
        for (int i = n + 1; i >= 0; i--) begin
            sup = (i < n) ? w[i] : 1'b0;
            repeat (20) @(negedge clk);
            sup = ~sup;
            repeat (20) @(negedge clk);
        end
    endtask : mcmd

    // read reply on the pwm pin: oe high pulls low, second half = bit
    task automatic mreply(input logic [15:0] e);
        logic [15:0] g;
        int t;
        g = '0;
        t = 0;
        while (!pwm_oe && t < 400) begin
            @(negedge clk);
            t++;
        end
        if (t >= 400) num_errors++;
        repeat (10) @(negedge clk);
        for (int k = 15; k >= 0; k--) begin
            g[k] = pwm_oe;
            repeat (40) @(negedge clk);
        end
        chk_word(g, e);
    endtask : mreply

    // answer to the previous read, found in the frame just sent
    task automatic back(input int n, input logic [15:0] e);
        logic [3:0] c;
        c = crc(e);
        chk_word(r[n-1 -: 16], e);
        if (n >= 20) chk_word({12'h000, r[n-17 -: 4]}, {12'h000, c});
        if (n == 21) chk_bit(r[0], c[3]);
    endtask : back

    task automatic results();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : results

    // ========================================================================
    // watchdog
    initial begin
        #200000;
        num_errors++;
        results();
    end

    // ========================================================================
    // main sequence
    initial begin
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        angle = 1'b0;
        repeat (8) @(negedge clk);
        chk_bit(pwm_oe, 1'b1);
        chk_bit(mode, 1'b0);
        xfer(16'h64A5, 16);
        xfer(16'h653C, 16);
        xfer(16'h2400, 20);
        xfer(16'h2500, 20);
        back(20, 16'hA53C);
        xfer(16'h0000, 21);
        back(21, 16'h003C);
        xfer(16'h0000, 16);
        back(16, 16'h0000);
        chk_bit(xw, 1'b0);
        xfer(16'h0000, 17);
        chk_bit(xw, 1'b1);
        clr = 1'b1;
        @(negedge clk);
        clr = 1'b0;
        en17 = 1'b1;
        xfer(16'h0000, 17);
        chk_bit(xw, 1'b0);
        xfer(16'h0000, 18);
        chk_bit(xw, 1'b1);
        crc_en = 1'b1;
        flip = 4'h5;
        xfer(16'h65FF, 20);
        flip = 4'h0;
        chk_bit(cw, 1'b1);
        xfer(16'h2400, 20);
        xfer(16'h0000, 16);
        back(16, 16'hA53C);
        xfer(16'h6511, 20);
        xfer(16'h2400, 20);
        xfer(16'h0000, 20);
        back(20, 16'hA511);
        // supply line: access code ignored while disabled, then taken
        mdis = 1'b1;
        mcmd({1'b0, 4'h0, 6'h3F, 16'h62D2, 3'b110}, 30);
        repeat (60) @(negedge clk);
        chk_bit(mode, 1'b0);
        mdis = 1'b0;
        mcmd({1'b0, 4'h2, 6'h3F, 16'h62D2, 3'b110}, 30);
        repeat (60) @(negedge clk);
        chk_bit(mode, 1'b1);
        chk_bit(pwm_oe, 1'b0);
        chk_bit(pwm_out, 1'b0);
        mcmd({16'h0000, 1'b1, 4'h2, 6'h24, 3'b000}, 14);
        mreply(16'hA511);
        results();
    end
endmodule : sensor_serial_access_port_tb_top

`default_nettype wire

/* File: test/ssap_host_model.sv */
/* host model: mode 3 spi master with an 80 ns serial clock.
   assumes a 5 ns i_clock; pins change at its falling edge. */
`default_nettype none

module ssap_host_model (
    // clock
    input wire logic i_clock,
    // spi pins
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_mosi,
    input wire logic i_miso
);
    timeunit 1ns;
    timeprecision 100ps;

    // ========================================================================
    // frame driver
    initial begin
        o_sclk = 1'b1;
        o_cs_n = 1'b1;
        o_mosi = 1'b0;
    end

    // half serial clock period
    task automatic half();
        repeat (8) @(negedge i_clock);
    endtask : half

    // one frame of n bits, msb first; miso taken at each rise
    task automatic frame(input logic [20:0] d, input int n,
                         output logic [20:0] r);
        r = '0;
        o_cs_n = 1'b0;
        half();
        for (int i = n - 1; i >= 0; i--) begin
            o_sclk = 1'b0;
            o_mosi = d[i];
            half();
            o_sclk = 1'b1;
            r[i] = i_miso;
            half();
        end
        o_mosi = ~o_mosi; // released line shows the inverse
        o_cs_n = 1'b1;
        repeat (48) @(negedge i_clock); // idle over 200 ns
    endtask : frame
endmodule : ssap_host_model

`default_nettype wire
